//--- logic/eif_top.sv
// external interrupt channels 4 and 5 with noise filters and APB registers
//
// Overview of operation
// - ch4 trigger: rise, fall, both, high level
// - capture filtered level on each ch4 request
// - both-edge mode: captured level shows direction
// - fast modes: three equal samples accept ch4 level, two accept ch5
// - interval select: every, 4, 8, 16 clocks
// - slow modes: lf/4 sampling, two samples
// - deep modes: sampling halted, no requests
// - sampling resumes on return from deep
// - output-mode pin reads low, may request
// - ch5 requests on falling edge only
// - ch5 fast: 1 clock rejected, 2 accepted
// - ch5 slow: 4 lf rejected, 8 accepted
// - clock gate resets off, blocks channel
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`default_nettype none
module eif_top
    import eif_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [2:0]        op_mode,
    input  wire logic              lf_tick,
    input  wire logic              ext_irq_ch4_pin,
    input  wire logic              ext_irq_ch5_pin,
    input  wire logic              ch4_pin_is_output,
    input  wire logic              ch5_pin_is_output,
    output logic                   ch4_irq_req,
    output logic                   ch5_irq_req
);
    eif_smp_if smp ();

    logic [1:0]  ch4_trigger_select_reg;
    logic [1:0]  ch4_sample_interval_reg;
    logic        ch4_captured_level_reg;
    logic [1:0]  chan_clock_gate_reg;
    logic        ch4_prev_reg;
    logic        ch5_prev_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        ch4_irq_req_reg;
    logic        ch5_irq_req_reg;

    logic        ch4_level;
    logic        ch5_level;
    logic        ch4_pin_eff;
    logic        ch5_pin_eff;
    logic        ch4_gate;
    logic        ch5_gate;
    logic        ch4_fire;
    logic        ch5_fire;
    logic        setup_phase;
    logic        wr_take;
    logic [31:0] rd_value;

    assign prdata      = prdata_reg;
    assign pready      = pready_reg;
    assign pslverr     = pslverr_reg;
    assign ch4_irq_req = ch4_irq_req_reg;
    assign ch5_irq_req = ch5_irq_req_reg;

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        return (a == OFS_CH4_CTRL) || (a == OFS_POWER_OFF) || (a == OFS_STATUS);
    endfunction

    // pin in output mode reads low at the filter
    assign ch4_pin_eff = ext_irq_ch4_pin & ~ch4_pin_is_output;
    assign ch5_pin_eff = ext_irq_ch5_pin & ~ch5_pin_is_output;

    assign ch4_gate = chan_clock_gate_reg[PWR_CH4_BIT];
    assign ch5_gate = chan_clock_gate_reg[PWR_CH5_BIT];

    eif_sample_divider u_div (
        .core_clk (core_clk),
        .resetn   (resetn),
        .op_mode  (op_mode),
        .lf_tick  (lf_tick),
        .spl_sel  (ch4_sample_interval_reg),
        .smp      (smp.src)
    );

    eif_noise_filter #(
        .FAST_SAMPLES (FAST_SAMPLES_CH4),
        .USE_INTERVAL (1'b1),
        .LVL_RST      (CH4_LVL_RST)
    ) u_ch4_filt (
        .core_clk (core_clk),
        .resetn   (resetn),
        .smp      (smp.snk),
        .gate_on  (ch4_gate),
        .pin_in   (ch4_pin_eff),
        .level    (ch4_level)
    );

    eif_noise_filter #(
        .FAST_SAMPLES (FAST_SAMPLES_CH5),
        .USE_INTERVAL (1'b0),
        .LVL_RST      (CH5_LVL_RST)
    ) u_ch5_filt (
        .core_clk (core_clk),
        .resetn   (resetn),
        .smp      (smp.snk),
        .gate_on  (ch5_gate),
        .pin_in   (ch5_pin_eff),
        .level    (ch5_level)
    );

    // request decode on accepted levels
    assign ch4_fire = smp.active && ch4_gate &&
                      eif_trig_hit(ch4_trigger_select_reg, ch4_level, ch4_prev_reg);
    assign ch5_fire = smp.active && ch5_gate &&
                      eif_trig_hit(TRIG_FALL, ch5_level, ch5_prev_reg);

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ch4_prev_reg <= CH4_LVL_RST;
            ch5_prev_reg <= CH5_LVL_RST;
        end else begin
            ch4_prev_reg <= ch4_level;
            ch5_prev_reg <= ch5_level;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ch4_irq_req_reg <= 1'b0;
            ch5_irq_req_reg <= 1'b0;
        end else begin
            ch4_irq_req_reg <= ch4_fire;
            ch5_irq_req_reg <= ch5_fire;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ch4_captured_level_reg <= CH4_LVL_RST;
        end else if (ch4_fire) begin
            ch4_captured_level_reg <= ch4_level;
        end
    end

    // apb slave: one-cycle access phase
    assign setup_phase = psel && !penable;
    assign wr_take     = psel && penable && pready_reg && pwrite;

    always_comb begin
        rd_value = 32'h0;
        unique case (paddr)
            OFS_CH4_CTRL: begin
                rd_value[CTRL_TRIG_LSB +: 2] = ch4_trigger_select_reg;
                rd_value[CTRL_SPL_LSB +: 2]  = ch4_sample_interval_reg;
                rd_value[CTRL_LVL_BIT]       = ch4_captured_level_reg;
            end
            OFS_POWER_OFF: begin
                rd_value[PWR_CH4_BIT] = chan_clock_gate_reg[PWR_CH4_BIT];
                rd_value[PWR_CH5_BIT] = chan_clock_gate_reg[PWR_CH5_BIT];
            end
            OFS_STATUS: begin
                rd_value[STAT_CH4_LVL_BIT] = ch4_level;
                rd_value[STAT_CH5_LVL_BIT] = ch5_level;
            end
            default: rd_value = 32'h0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup_phase;
            if (setup_phase) begin
                prdata_reg  <= pwrite ? 32'h0 : rd_value;
                pslverr_reg <= !addr_hit(paddr);
            end else begin
                prdata_reg  <= 32'h0;
                pslverr_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ch4_trigger_select_reg  <= CTRL_TRIG_RST;
            ch4_sample_interval_reg <= CTRL_SPL_RST;
        end else if (wr_take && paddr == OFS_CH4_CTRL) begin
            ch4_trigger_select_reg  <= pwdata[CTRL_TRIG_LSB +: 2];
            ch4_sample_interval_reg <= pwdata[CTRL_SPL_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            chan_clock_gate_reg <= PWR_GATE_RST;
        end else if (wr_take && paddr == OFS_POWER_OFF) begin
            chan_clock_gate_reg[PWR_CH4_BIT] <= pwdata[PWR_CH4_BIT];
            chan_clock_gate_reg[PWR_CH5_BIT] <= pwdata[PWR_CH5_BIT];
        end
    end

    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_high_held;
        (smp.active && ch4_gate && ch4_trigger_select_reg == TRIG_HIGH && ch4_level) [*2];
    endsequence

    sequence s_rise_seen;
        smp.active && ch4_gate && ch4_trigger_select_reg == TRIG_RISE &&
        ch4_level && !ch4_prev_reg;
    endsequence

    a_apb_one_wait: assert property (setup_phase |=> pready_reg ##1 !pready_reg)
        else $error("apb access phase not one cycle");
    a_deep_no_req: assert property (
        !eif_is_active(op_mode) |=> !ch4_irq_req_reg && !ch5_irq_req_reg)
        else $error("request raised in deep mode");
    a_gate_blocks_req: assert property (
        !ch4_gate && !ch5_gate |=> !ch4_irq_req_reg && !ch5_irq_req_reg)
        else $error("request raised with channel clock off");
    a_rise_request: assert property (s_rise_seen |=> ch4_irq_req_reg)
        else $error("rising edge missed");
    a_fall_request: assert property (
        smp.active && ch4_gate && ch4_trigger_select_reg == TRIG_FALL &&
        !ch4_level && ch4_prev_reg |=> ch4_irq_req_reg)
        else $error("falling edge missed");
    a_both_edge_dir: assert property (
        smp.active && ch4_gate && ch4_trigger_select_reg == TRIG_BOTH &&
        ch4_level != ch4_prev_reg |=> ch4_irq_req_reg && ch4_captured_level_reg == ch4_prev_reg)
        else $error("both-edge request or direction wrong");
    a_high_level_req: assert property (
        s_high_held |=> ch4_irq_req_reg && $past(ch4_irq_req_reg))
        else $error("high level request not repeated");
    a_cap_on_request: assert property (
        ch4_irq_req_reg |-> ch4_captured_level_reg == $past(ch4_level))
        else $error("captured level not updated");
    a_ch5_fall_only: assert property (
        ch5_irq_req_reg |-> $past(ch5_prev_reg) && !$past(ch5_level))
        else $error("ch5 request without falling edge");
    a_edge_from_level: assert property (
        ch4_irq_req_reg && $past(ch4_trigger_select_reg) != TRIG_HIGH |->
        $past(ch4_level) != $past(ch4_prev_reg))
        else $error("edge request without level change");

    // acceptance, tick spacing and per-channel gating
    sequence s_ch4_agree3;
        (smp.active && ch4_gate && !smp.slow_mode &&
         ch4_sample_interval_reg == SPL_EVERY && ch4_pin_eff) [*3];
    endsequence

    sequence s_ch5_low2;
        (smp.active && ch5_gate && !smp.slow_mode && !ch5_pin_eff) [*2];
    endsequence

    a_ch4_three_agree: assert property (
        s_ch4_agree3 ##1 (smp.active && ch4_gate && !smp.slow_mode) |=> ch4_level)
        else $error("three agreeing samples not accepted");
    a_ch5_two_clk: assert property (
        s_ch5_low2 ##1 (smp.active && ch5_gate && !smp.slow_mode) |=> !ch5_level)
        else $error("two clock low pulse not accepted");
    a_ch5_one_pulse: assert property (ch5_irq_req_reg |=> !ch5_irq_req_reg)
        else $error("ch5 request longer than one cycle");
    a_ch4_edge_once: assert property (
        ch4_irq_req_reg && ch4_trigger_select_reg != TRIG_HIGH &&
        $past(ch4_trigger_select_reg) != TRIG_HIGH |=> !ch4_irq_req_reg)
        else $error("edge request longer than one cycle");
    a_cap_holds: assert property (!ch4_fire |=> $stable(ch4_captured_level_reg))
        else $error("captured level moved without request");
    a_fast_tick_every: assert property (
        smp.active && !smp.slow_mode && ch4_sample_interval_reg == SPL_EVERY |=> smp.ch4_tick)
        else $error("sample tick missing at full rate");
    a_slow_tick_gap: assert property (smp.slow_tick |=> !smp.slow_tick [*3])
        else $error("slow sample ticks too close");
    a_ch4_gate_off: assert property (!ch4_gate |=> !ch4_irq_req_reg)
        else $error("ch4 request with its clock gate off");
    a_ch5_gate_off: assert property (!ch5_gate |=> !ch5_irq_req_reg)
        else $error("ch5 request with its clock gate off");
    a_apb_idle_quiet: assert property (!setup_phase |=> prdata_reg == 32'h0 && !pslverr_reg)
        else $error("apb answer outside access phase");
endmodule
`default_nettype wire

//--- common/eif_pkg.sv
// shared constants and decoders for the external interrupt filter block
`default_nettype none
package eif_pkg;
    // operating modes seen on op_mode
    localparam logic [2:0] MODE_FAST_RUN   = 3'h0;
    localparam logic [2:0] MODE_FAST_IDLE  = 3'h1;
    localparam logic [2:0] MODE_SLOW_RUN   = 3'h2;
    localparam logic [2:0] MODE_SLOW_SLEEP = 3'h3;
    localparam logic [2:0] MODE_DEEP_IDLE  = 3'h4;
    localparam logic [2:0] MODE_DEEP_SLEEP = 3'h5;
    localparam logic [2:0] MODE_STOP       = 3'h6;

    // trigger select codes
    localparam logic [1:0] TRIG_RISE = 2'h0;
    localparam logic [1:0] TRIG_FALL = 2'h1;
    localparam logic [1:0] TRIG_BOTH = 2'h2;
    localparam logic [1:0] TRIG_HIGH = 2'h3;

    // sample interval codes
    localparam logic [1:0] SPL_EVERY = 2'h0;
    localparam logic [1:0] SPL_DIV4  = 2'h1;
    localparam logic [1:0] SPL_DIV8  = 2'h2;
    localparam logic [1:0] SPL_DIV16 = 2'h3;

    // register map
    localparam int         ADDR_W        = 12;
    localparam logic [11:0] OFS_CH4_CTRL = 12'h000;
    localparam logic [11:0] OFS_POWER_OFF = 12'h004;
    localparam logic [11:0] OFS_STATUS   = 12'h008;

    // field positions
    localparam int CTRL_TRIG_LSB    = 0;
    localparam int CTRL_SPL_LSB     = 2;
    localparam int CTRL_LVL_BIT     = 4;
    localparam int PWR_CH4_BIT      = 0;
    localparam int PWR_CH5_BIT      = 1;
    localparam int STAT_CH4_LVL_BIT = 0;
    localparam int STAT_CH5_LVL_BIT = 1;

    // reset values
    localparam logic [1:0] CTRL_TRIG_RST = 2'h0;
    localparam logic [1:0] CTRL_SPL_RST  = 2'h0;
    localparam logic [1:0] PWR_GATE_RST  = 2'h0;
    localparam logic       CH4_LVL_RST   = 1'b0;
    localparam logic       CH5_LVL_RST   = 1'b1;

    // timing counts
    localparam int LF_DIV           = 4;
    localparam int FAST_SAMPLES_CH4 = 3;
    localparam int FAST_SAMPLES_CH5 = 2;
    localparam int SLOW_SAMPLES     = 2;

    function automatic logic eif_is_active(input logic [2:0] mode);
        return (mode == MODE_FAST_RUN) || (mode == MODE_FAST_IDLE) ||
               (mode == MODE_SLOW_RUN) || (mode == MODE_SLOW_SLEEP);
    endfunction

    function automatic logic eif_is_slow(input logic [2:0] mode);
        return (mode == MODE_SLOW_RUN) || (mode == MODE_SLOW_SLEEP);
    endfunction

    function automatic logic eif_trig_hit(input logic [1:0] sel,
                                          input logic       lvl,
                                          input logic       prev);
        logic hit;
        unique case (sel)
            TRIG_RISE: hit = lvl & ~prev;
            TRIG_FALL: hit = ~lvl & prev;
            TRIG_BOTH: hit = lvl ^ prev;
            TRIG_HIGH: hit = lvl;
        endcase
        return hit;
    endfunction
endpackage
`default_nettype wire

//--- common/eif_smp_if.sv
// sampling strobes from the divider to the noise filters
`default_nettype none
interface eif_smp_if;
    logic active;
    logic slow_mode;
    logic slow_tick;
    logic ch4_tick;
    modport src (output active, output slow_mode, output slow_tick, output ch4_tick);
    modport snk (input active, input slow_mode, input slow_tick, input ch4_tick);
endinterface
`default_nettype wire

//--- logic/eif_sample_divider.sv
// sampling strobe generator for fast and slow modes
`default_nettype none
module eif_sample_divider
    import eif_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic [2:0] op_mode,
    input  wire logic       lf_tick,
    input  wire logic [1:0] spl_sel,
    eif_smp_if.src          smp
);
    logic [1:0] lf_cnt_reg;
    logic [3:0] gear_cnt_reg;
    logic       slow_tick_reg;
    logic       ch4_tick_reg;
    logic [3:0] mask;

    assign smp.active    = eif_is_active(op_mode);
    assign smp.slow_mode = eif_is_slow(op_mode);
    assign smp.slow_tick = slow_tick_reg;
    assign smp.ch4_tick  = ch4_tick_reg;

    always_comb begin
        unique case (spl_sel)
            SPL_EVERY: mask = 4'h0;
            SPL_DIV4:  mask = 4'h3;
            SPL_DIV8:  mask = 4'h7;
            SPL_DIV16: mask = 4'hf;
        endcase
    end

    // low-frequency ticks divided by four, frozen in deep modes
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            lf_cnt_reg    <= 2'h0;
            slow_tick_reg <= 1'b0;
        end else begin
            if (smp.active && smp.slow_mode && lf_tick) begin
                lf_cnt_reg <= lf_cnt_reg + 2'h1;
            end
            slow_tick_reg <= smp.active && smp.slow_mode && lf_tick &&
                             (lf_cnt_reg == 2'(LF_DIV - 1));
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            gear_cnt_reg <= 4'h0;
            ch4_tick_reg <= 1'b0;
        end else begin
            if (smp.active && !smp.slow_mode) begin
                gear_cnt_reg <= gear_cnt_reg + 4'h1;
            end
            ch4_tick_reg <= smp.active && !smp.slow_mode &&
                            ((gear_cnt_reg & mask) == 4'h0);
        end
    end
endmodule
`default_nettype wire

//--- logic/eif_noise_filter.sv
// sample-and-agree noise canceller for one pin
`default_nettype none
module eif_noise_filter
    import eif_pkg::*;
#(
    parameter int   FAST_SAMPLES = FAST_SAMPLES_CH4,
    parameter bit   USE_INTERVAL = 1'b1,
    parameter logic LVL_RST      = 1'b0
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    eif_smp_if.snk    smp,
    input  wire logic gate_on,
    input  wire logic pin_in,
    output logic      level
);
    logic       pin_q;
    logic [1:0] hist_reg;
    logic       prev_samp;
    logic       tick;
    logic       match;

    assign prev_samp = hist_reg[0];

    always_comb begin
        tick = 1'b0;
        if (smp.active && gate_on) begin
            tick = smp.slow_mode ? smp.slow_tick : (USE_INTERVAL ? smp.ch4_tick : 1'b1);
        end
        match = (pin_q == hist_reg[0]);
        if (!smp.slow_mode && FAST_SAMPLES > SLOW_SAMPLES) begin
            match = match && (pin_q == hist_reg[1]);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pin_q <= LVL_RST;
        end else begin
            pin_q <= pin_in;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            hist_reg <= {2{LVL_RST}};
        end else if (tick) begin
            hist_reg <= {hist_reg[0], pin_q};
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            level <= LVL_RST;
        end else if (tick && match) begin
            level <= pin_q;
        end
    end

    a_hold_when_off: assert property (@(posedge core_clk) disable iff (!resetn)
        !(smp.active && gate_on) |=> $stable(level))
        else $error("filtered level moved while sampling stopped");
    a_level_agrees: assert property (@(posedge core_clk) disable iff (!resetn)
        $changed(level) |-> $past(tick) && $past(pin_q) == level && $past(prev_samp) == level)
        else $error("filtered level accepted without agreeing samples");
endmodule
`default_nettype wire

//--- bench/eif_pin_src.sv
// external signal source model driving both interrupt pins
`default_nettype none
module eif_pin_src (
    input  wire logic core_clk,
    output logic      pin4,
    output logic      pin5
);
    timeunit 1ns;
    timeprecision 1ps;

    // ch4 idles low, ch5 idles high
    initial begin
        pin4 = 1'b0;
        pin5 = 1'b1;
    end

    // away from idle for w clocks; caller sizes w against the interval
    task automatic pulse(input logic ch5, input int w);
        @(posedge core_clk);
        if (ch5) begin
            pin5 <= 1'b0;
        end else begin
            pin4 <= 1'b1;
        end
        repeat (w) @(posedge core_clk);
        if (ch5) begin
            pin5 <= 1'b1;
        end else begin
            pin4 <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

//--- bench/ext_irq_edge_level_filter_tb.sv
// self-checking bench for the external interrupt filter block
`default_nettype none
module ext_irq_edge_level_filter_tb import eif_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LF_PER = 4;

    logic              core_clk, resetn, psel, penable, pwrite, lf_tick;
    logic              pready, pslverr, ch4_irq_req, ch5_irq_req, pin4, pin5;
    logic              ch4_out, ch5_out;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata;
    logic [2:0]        op_mode;
    int                n_fail, comparisons;
    int                lf_cnt = 0;
    logic [33:0]       q_apb[$];
    logic [3:0]        q_irq[$];

    eif_top eif_top_i (
        .core_clk(core_clk), .resetn(resetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .op_mode(op_mode), .lf_tick(lf_tick),
        .ext_irq_ch4_pin(pin4), .ext_irq_ch5_pin(pin5),
        .ch4_pin_is_output(ch4_out), .ch5_pin_is_output(ch5_out),
        .ch4_irq_req(ch4_irq_req), .ch5_irq_req(ch5_irq_req)
    );

    eif_pin_src eif_pin_src_i (.core_clk(core_clk), .pin4(pin4), .pin5(pin5));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // one lf_tick pulse per low_freq_clock period
    always @(posedge core_clk) begin
        lf_cnt <= (lf_cnt == LF_PER - 1) ? 0 : lf_cnt + 1;
        lf_tick <= (lf_cnt == LF_PER - 1);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t ns: got %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic take(input logic r, input logic [3:0] ch);
        if (q_irq.size() == 0) begin
            check({r, ch}, 5'h0);
        end else begin
            check({r, ch}, {1'b1, q_irq.pop_front()});
        end
    endtask

    // result watcher: apb answers and request pulses
    always @(posedge core_clk) begin
        logic [33:0] e;
        if (psel && penable && pready === 1'b1) begin
            e = q_apb.pop_front();
            check(pslverr, e[32]);
            if (e[33]) begin
                check(prdata, e[31:0]);
            end
        end
        // requests are unknown until the first reset edge
        if (resetn === 1'b1 && ch4_irq_req !== 1'b0) begin
            take(ch4_irq_req, 4'h4);
        end
        if (resetn === 1'b1 && ch5_irq_req !== 1'b0) begin
            take(ch5_irq_req, 4'h5);
        end
    end

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic err, input logic [31:0] exp);
        @(posedge core_clk);
        q_apb.push_back({~wr, err, exp});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // only the watchdog ends a wait for pready
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        check(q_irq.size(), 32'h0);
    endtask

    initial begin
        #100000;
        check(32'h0, 32'h1);
        stop_test();
    end

    initial begin
        int w;
        int n;
        w = $urandom(50917);
        {resetn, psel, penable, pwrite, ch4_out, ch5_out} = '0;
        paddr = ADDR_W'($urandom);
        pwdata = $urandom;
        op_mode = MODE_FAST_RUN;
        n_fail = 0;
        comparisons = 0;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        // reset values, unmapped place, gates off
        apb(1'b0, OFS_CH4_CTRL, 32'h0, 1'b0, 32'h0);
        apb(1'b0, OFS_POWER_OFF, 32'h0, 1'b0, 32'h0);
        apb(1'b0, OFS_STATUS, 32'h0, 1'b0, 32'h2);
        apb(1'b1, 12'h00c, 32'hffff_ffff, 1'b1, 32'h0);
        apb(1'b0, 12'h00c, 32'h0, 1'b1, 32'h0);
        eif_pin_src_i.pulse(1'b0, 10);
        eif_pin_src_i.pulse(1'b1, 10);
        settle(30);
        apb(1'b1, OFS_POWER_OFF, 32'h3, 1'b0, 32'h0);
        apb(1'b0, OFS_POWER_OFF, 32'h0, 1'b0, 32'h3);
        // every trigger code, captured level read mid-pulse and after
        for (int i = 0; i < 4; i++) begin
            w = 24 + ($urandom % 8);
            apb(1'b1, OFS_CH4_CTRL, i, 1'b0, 32'h0);
            if (i != 3) q_irq.push_back(4'h4);
            if (i == 2) q_irq.push_back(4'h4);
            if (i == 3) repeat (w) q_irq.push_back(4'h4);
            fork
                eif_pin_src_i.pulse(1'b0, w);
                begin
                    repeat (15) @(posedge core_clk);
                    apb(1'b0, OFS_CH4_CTRL, 32'h0, 1'b0, 32'h10 | i);
                end
            join
            settle(20);
            apb(1'b0, OFS_CH4_CTRL, 32'h0, 1'b0, {27'h0, i == 0 || i == 3, 4'(i)});
        end
        // each sample interval: two-interval pulse dropped, four-interval kept
        for (int i = 0; i < 4; i++) begin
            n = (i == 0) ? 1 : (2 << i);
            apb(1'b1, OFS_CH4_CTRL, i << CTRL_SPL_LSB, 1'b0, 32'h0);
            eif_pin_src_i.pulse(1'b0, 2 * n);
            settle(8 * n + 10);
            q_irq.push_back(4'h4);
            eif_pin_src_i.pulse(1'b0, 4 * n);
            settle(8 * n + 10);
        end
        // ch5 fast: one clock dropped, two kept, rise ignored
        eif_pin_src_i.pulse(1'b1, 1);
        settle(8);
        q_irq.push_back(4'h5);
        eif_pin_src_i.pulse(1'b1, 2);
        settle(12);
        // slow run mode
        apb(1'b1, OFS_CH4_CTRL, 32'h0, 1'b0, 32'h0);
        @(posedge core_clk);
        op_mode <= MODE_SLOW_RUN;
        settle(12 * LF_PER);
        eif_pin_src_i.pulse(1'b0, 3 * LF_PER);
        eif_pin_src_i.pulse(1'b1, 3 * LF_PER);
        settle(40 * LF_PER);
        q_irq.push_back(4'h4);
        eif_pin_src_i.pulse(1'b0, 10 * LF_PER);
        settle(20 * LF_PER);
        q_irq.push_back(4'h5);
        eif_pin_src_i.pulse(1'b1, 8 * LF_PER);
        settle(20 * LF_PER);
        // deep modes halt, fast idle resumes
        for (int m = 4; m < 7; m++) begin
            @(posedge core_clk);
            op_mode <= m[2:0];
            eif_pin_src_i.pulse(1'b0, 40);
            eif_pin_src_i.pulse(1'b1, 40);
            settle(20);
        end
        @(posedge core_clk);
        op_mode <= MODE_FAST_IDLE;
        settle(20);
        q_irq.push_back(4'h4);
        eif_pin_src_i.pulse(1'b0, 8);
        q_irq.push_back(4'h5);
        eif_pin_src_i.pulse(1'b1, 8);
        settle(20);
        // output mode forces the ch5 input low
        q_irq.push_back(4'h5);
        ch5_out <= 1'b1;
        settle(12);
        ch5_out <= 1'b0;
        settle(12);
        // random control write; captured level bit ignores writes
        w = $urandom;
        apb(1'b1, OFS_CH4_CTRL, w, 1'b0, 32'h0);
        apb(1'b0, OFS_CH4_CTRL, 32'h0, 1'b0, {27'h0, 1'b1, 4'(w)});
        apb(1'b0, OFS_STATUS, 32'h0, 1'b0, 32'h2);
        // output mode forces the ch4 input low mid-pulse, falling trigger
        apb(1'b1, OFS_CH4_CTRL, 32'h1, 1'b0, 32'h0);
        repeat (2) q_irq.push_back(4'h4);
        fork
            eif_pin_src_i.pulse(1'b0, 40);
            begin
                repeat (15) @(posedge core_clk);
                ch4_out <= 1'b1;
                repeat (10) @(posedge core_clk);
                ch4_out <= 1'b0;
            end
        join
        settle(20);
        apb(1'b0, OFS_CH4_CTRL, 32'h0, 1'b0, 32'h1);
        stop_test();
    end
endmodule
`default_nettype wire
